// *** rtl/irq_timer_consts.svh ***
/*
 * Constants for the interrupt controller and free-running timer:
 * field positions, reset values and timing counts.
 * Assumes a 125 MHz core clock and a 1 MHz tick strobe on that clock.
 */
`ifndef IRQ_TIMER_CONSTS_SVH
`define IRQ_TIMER_CONSTS_SVH

`define TMR_WIDTH 12
`define TMR_RESET 12'h000
`define TMR_MAX 12'hfff
// 1 MHz tick: each count is 1 us, so bit 6 toggles every 64 us (128 us period)
`define TMR_TICK_NS 1000
`define TAP_128US_PERIOD_US 128
`define TAP_1MS_PERIOD_US 1024
`define TAP_128US_BIT 6
`define TAP_1MS_BIT 9
`define IRQ_COUNT 7
`define GPIO_WIDTH 10
`define IRQ_BUS_RESET 0
`define IRQ_TAP_128US 1
`define IRQ_TAP_1MS 2
`define IRQ_EP0 3
`define IRQ_EP1 4
`define IRQ_GPIO 5
`define IRQ_WAKEUP 6
`define IRQ_NONE_VEC 3'h7
`define MASK_RESET 7'h00
`define GPIO_RESET 10'h000

`endif

// *** rtl/irq_timer_pkg.sv ***
/*
 * Types shared by the interrupt controller.
 * Assumes irq_timer_consts.svh supplies widths.
 */
`include "irq_timer_consts.svh"
`default_nettype none
package irq_timer_pkg;
  typedef logic [`IRQ_COUNT-1:0] irq_vec_t;
  typedef logic [`GPIO_WIDTH-1:0] gpio_t;
  // one request toward the core
  typedef struct packed {
    logic valid;
    logic [2:0] vector;
  } irq_req_s;
  // per-pin gpio interrupt configuration
  typedef struct packed {
    gpio_t enable;
    gpio_t rising;
  } gpio_cfg_s;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REQ = 2'b01,
    ST_WAIT = 2'b11
  } dispatch_e;
endpackage
`default_nettype wire

// *** rtl/interrupt_and_timer_events.sv ***
/*
 * Vectored interrupt controller with the 12-bit free-running timer.
 * Assumes tick_1mhz is a one-cycle strobe on clk, event inputs are clk-domain
 * pulses, gpio_pins come from pads, and the core acks each dispatched vector.
 */
`include "irq_timer_consts.svh"
`default_nettype none
module interrupt_and_timer_events (
  input wire logic clk,
  input wire logic reset,
  input wire logic tick_1mhz,
  input wire logic timer_irq_enable,
  input wire logic bus_reset_event,
  input wire logic ep0_done,
  input wire logic ep1_done,
  input wire logic wakeup_event,
  input wire irq_timer_pkg::gpio_t gpio_pins,
  input wire irq_timer_pkg::gpio_cfg_s gpio_cfg,
  input wire irq_timer_pkg::irq_vec_t irq_mask,
  input wire logic global_enable,
  input wire logic irq_ack,
  output logic [`TMR_WIDTH-1:0] timer_count,
  output irq_timer_pkg::irq_vec_t irq_pending,
  output irq_timer_pkg::irq_req_s irq_req
);
  logic [`TMR_WIDTH-1:0] count_reg;
  logic [`TMR_WIDTH-1:0] count_next;
  irq_timer_pkg::gpio_t pin_synced;
  irq_timer_pkg::gpio_t pin_last_reg;
  irq_timer_pkg::irq_vec_t pend_reg;
  irq_timer_pkg::irq_vec_t pend_next;
  irq_timer_pkg::irq_vec_t events;
  irq_timer_pkg::irq_vec_t ready;
  irq_timer_pkg::irq_req_s req_reg;
  irq_timer_pkg::irq_req_s req_next;
  irq_timer_pkg::dispatch_e state_reg;
  irq_timer_pkg::dispatch_e state_next;
  irq_timer_pkg::irq_vec_t grant_clear;
  irq_timer_pkg::gpio_t pin_rise;
  irq_timer_pkg::gpio_t pin_fall;
  irq_timer_pkg::gpio_t pin_hit;
  logic tap_128_rise;
  logic tap_1ms_rise;
  logic [2:0] pick_vec;
  logic pick_valid;

  // wraps naturally at the 12-bit boundary
  assign count_next = tick_1mhz ? count_reg + `TMR_WIDTH'(1) : count_reg;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_reg <= `TMR_RESET;
    end else begin
      count_reg <= count_next;
    end
  end

  // read path is a plain copy, so reading never affects counting
  assign timer_count = count_reg;

  // a tap fires when its bit goes high: once per full period of that bit
  tap_edge #(
    .BIT(`TAP_128US_BIT)
  ) tap_fast (
    .tick(tick_1mhz),
    .count_now(count_reg),
    .count_after(count_next),
    .rise(tap_128_rise)
  );
  tap_edge #(
    .BIT(`TAP_1MS_BIT)
  ) tap_slow (
    .tick(tick_1mhz),
    .count_now(count_reg),
    .count_after(count_next),
    .rise(tap_1ms_rise)
  );

  // gpio pads: two flops, then edge detect on the synced copy only
  pin_sync #(
    .WIDTH(`GPIO_WIDTH)
  ) gpio_sync (
    .clk(clk),
    .reset(reset),
    .pins(gpio_pins),
    .synced(pin_synced)
  );

  // history starts low, so a pin high at release reads as a rising edge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_last_reg <= `GPIO_RESET;
    end else begin
      pin_last_reg <= pin_synced;
    end
  end

  assign pin_rise = pin_synced & ~pin_last_reg;
  assign pin_fall = ~pin_synced & pin_last_reg;
  assign pin_hit = (gpio_cfg.rising & pin_rise) | (~gpio_cfg.rising & pin_fall);
  // disabled pins never contribute
  wire gpio_event = |(pin_hit & gpio_cfg.enable);

  assign events[`IRQ_BUS_RESET] = bus_reset_event;
  assign events[`IRQ_TAP_128US] = timer_irq_enable && tap_128_rise;
  assign events[`IRQ_TAP_1MS] = timer_irq_enable && tap_1ms_rise;
  assign events[`IRQ_EP0] = ep0_done;
  assign events[`IRQ_EP1] = ep1_done;
  assign events[`IRQ_GPIO] = gpio_event;
  assign events[`IRQ_WAKEUP] = wakeup_event;

  // a new event in the grant cycle survives: set wins over clear
  assign pend_next = (pend_reg & ~grant_clear) | events;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pend_reg <= `MASK_RESET;
    end else begin
      pend_reg <= pend_next;
    end
  end

  assign irq_pending = pend_reg;
  assign ready = pend_reg & irq_mask;

  // fixed priority: lowest index (bus reset) first
  always_comb begin
    pick_vec = `IRQ_NONE_VEC;
    pick_valid = 1'b0;
    for (int i = `IRQ_COUNT - 1; i >= 0; i--) begin
      if (ready[i]) begin
        pick_vec = 3'(i);
        pick_valid = 1'b1;
      end
    end
  end

  // one vector per source, held until the core acks it
  always_comb begin
    state_next = state_reg;
    req_next = req_reg;
    grant_clear = '0;
    unique case (state_reg)
      irq_timer_pkg::ST_IDLE: begin
        if (pick_valid && global_enable) begin
          req_next.valid = 1'b1;
          req_next.vector = pick_vec;
          state_next = irq_timer_pkg::ST_REQ;
        end
      end
      irq_timer_pkg::ST_REQ: begin
        if (irq_ack) begin
          grant_clear[req_reg.vector] = 1'b1;
          req_next.valid = 1'b0;
          state_next = irq_timer_pkg::ST_WAIT;
        end
      end
      irq_timer_pkg::ST_WAIT: begin
        // one idle cycle lets the core mask further requests on entry
        state_next = irq_timer_pkg::ST_IDLE;
      end
      default: begin
        state_next = irq_timer_pkg::ST_IDLE;
        req_next.valid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= irq_timer_pkg::ST_IDLE;
      req_reg <= '0;
    end else begin
      state_reg <= state_next;
      req_reg <= req_next;
    end
  end

  assign irq_req = req_reg;
endmodule

// strobe when the watched count bit goes from low to high on a tick
module tap_edge #(
  parameter int BIT = 0
) (
  input wire logic tick,
  input wire logic [`TMR_WIDTH-1:0] count_now,
  input wire logic [`TMR_WIDTH-1:0] count_after,
  output logic rise
);
  // one strobe per full period of the watched bit, not per half period
  assign rise = tick && count_after[BIT] && !count_now[BIT];
endmodule

// two-flop synchroniser for asynchronous pad levels
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] pins,
  output logic [WIDTH-1:0] synced
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // only sync_reg leaves here: meta_reg may still be settling
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= pins;
      sync_reg <= meta_reg;
    end
  end

  assign synced = sync_reg;
endmodule
`default_nettype wire

// *** testbench/interrupt_and_timer_events_asserts.sv ***
/* port checker for the controller; bound to every instance of its top module */
`default_nettype none
module interrupt_and_timer_events_asserts (
  input wire logic clk,
  input wire logic reset,
  input wire logic tick_1mhz,
  input wire logic timer_irq_enable,
  input wire logic ep0_done,
  input wire logic irq_ack,
  input wire irq_timer_pkg::irq_vec_t irq_mask,
  input wire logic [11:0] timer_count,
  input wire irq_timer_pkg::irq_vec_t irq_pending,
  input wire irq_timer_pkg::irq_req_s irq_req
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  a_tick_step: assert property (tick_1mhz |=> timer_count == $past(timer_count) + 12'h001)
    else $error("count step");
  a_count_hold: assert property (!tick_1mhz |=> $stable(timer_count))
    else $error("count moved");
  a_tap_fast: assert property (
    tick_1mhz && timer_irq_enable && timer_count[6:0] == 7'h3f |-> ##[1:2] irq_pending[1])
    else $error("fast tap");
  a_tap_slow: assert property (
    tick_1mhz && timer_irq_enable && timer_count[9:0] == 10'h1ff |-> ##[1:2] irq_pending[2])
    else $error("slow tap");
  a_ep_pend: assert property (ep0_done |=> irq_pending[3])
    else $error("endpoint pend");
  a_req_hold: assert property (irq_req.valid && !irq_ack |=> irq_req.valid && $stable(irq_req))
    else $error("request dropped");
  a_ack_drop: assert property (irq_req.valid && irq_ack |=> !irq_req.valid ##1 !irq_req.valid)
    else $error("ack drop");
  a_lowest_first: assert property ($rose(irq_req.valid) |->
    ($past(irq_pending) & $past(irq_mask) & ((7'h01 << irq_req.vector) - 7'h01)) == 7'h00)
    else $error("priority");
  cover property (irq_req.valid && irq_ack);
  cover property (tick_1mhz && timer_count == 12'hfff);
  cover property ($rose(irq_pending[5]));
endmodule
bind interrupt_and_timer_events interrupt_and_timer_events_asserts chk (.*);
`default_nettype wire

// *** testbench/core_model.sv ***
/* core stand-in: acks each request after delay cycles; drives on the falling edge */
`default_nettype none
module core_model (
  input wire logic clk,
  input wire logic reset,
  input wire irq_timer_pkg::irq_req_s irq_req,
  input wire logic [1:0] delay,
  output logic irq_ack
);
  int w = 0;
  initial irq_ack = 0;
  always @(negedge clk) begin
    irq_ack <= 0;
    // no second ack for a request already taken
    if (!reset && irq_req.valid === 1'b1 && !irq_ack) begin
      w = w + 1;
      if (w > delay) begin
        irq_ack <= 1;
        w = 0;
      end
    end
  end
endmodule
`default_nettype wire

// *** testbench/interrupt_and_timer_events_test.sv ***
/* bench for timer, dispatch and gpio edges; core_model acks the requests */
`default_nettype none
module interrupt_and_timer_events_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, reset = 1, tick_1mhz = 0, timer_irq_enable = 0, global_enable = 0, irq_ack;
  logic [3:0] ev = 0;
  logic [1:0] delay = 0;
  wire logic bus_reset_event, ep0_done, ep1_done, wakeup_event;
  irq_timer_pkg::gpio_t gpio_pins = 0;
  irq_timer_pkg::gpio_cfg_s gpio_cfg = 0;
  irq_timer_pkg::irq_vec_t irq_mask = 7'h79, irq_pending;
  irq_timer_pkg::irq_req_s irq_req;
  logic [11:0] timer_count, got_q[$];
  int exp_q[$], vecs[4] = '{0, 3, 4, 6};
  int n_mismatch = 0, cmp_count = 0, seed = 19559, p;
  assign {wakeup_event, ep1_done, ep0_done, bus_reset_event} = ev;
  interrupt_and_timer_events dut (.*);
  core_model core (.*);
  initial forever #4 clk = ~clk;
  always @(posedge clk)
    if (irq_req.valid === 1'b1 && irq_ack === 1'b1) got_q.push_back(12'(irq_req.vector));
  task automatic check(input logic [11:0] got, input logic [11:0] want);
    cmp_count++;
    if (got !== want) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic drain(input int n);
    repeat (n) @(negedge clk);
    check(12'(got_q.size()), 12'(exp_q.size()));
    while (got_q.size() > 0 && exp_q.size() > 0) check(got_q.pop_front(), 12'(exp_q.pop_front()));
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #400000;
    n_mismatch++;
    results();
  end
  initial begin
    repeat (3) @(negedge clk);
    reset = 0;
    for (int i = 1; i <= 4096; i++) begin
      timer_irq_enable = i > 600;
      tick_1mhz = 1;
      @(negedge clk);
      tick_1mhz = 0;
      @(negedge clk);
      check(timer_count, 12'(i));
      if (i == 600) check(12'(irq_pending), 12'h000);
    end
    check(12'(irq_pending), 12'h006);
    $display("timer test done");
    global_enable = 1;
    for (int i = 0; i < 24; i++) begin
      p = {$random(seed)} % 4;
      delay = 2'($random(seed));
      ev = 4'h1 << p;
      exp_q.push_back(vecs[p]);
      @(negedge clk);
      ev = 0;
      drain(12);
    end
    global_enable = 0;
    ev = 4'hf;
    @(negedge clk);
    ev = 0;
    repeat (5) @(negedge clk);
    exp_q = '{0, 3, 4, 6};
    global_enable = 1;
    drain(60);
    $display("dispatch test done");
    for (int i = 0; i < 40; i++) begin
      gpio_cfg = 20'($random(seed));
      p = {$random(seed)} % 10;
      gpio_pins[p] = ~gpio_pins[p];
      if (gpio_cfg.enable[p] && gpio_cfg.rising[p] == gpio_pins[p]) exp_q.push_back(5);
      drain(12);
    end
    $display("gpio test done");
    results();
  end
endmodule
`default_nettype wire
